/* File: rtl/pfd_pkg.sv */
// Overview of operation
// - swap bit exchanges reference and oscillator inputs
// - swapped inputs reverse the pump direction
// - force-up bit holds up pump on
// - force-down bit holds lower pump on
// - slip guard machine holds pump one way
// - slip guard needs enable and output enable
// - hold polarity until frequency error nears zero
// - three-bit delay sets slip sensitivity
// - two saturation flags show which input leads
// - up code bits 6:0, down 13:7
// - codes independent, 127 steps to 2.54 mA
// - offset magnitude from bits 20:14
// - offset to up bit 21, down bit 22
// - high gain adds fixed 3.5 mA
// - high gain works with zero codes
package pfd_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [6:0] SLIP_ENABLES_ADDR = 7'h01;
  localparam logic [6:0] DET_SWAP_ADDR = 7'h03;
  localparam logic [6:0] PUMP_CFG_ADDR = 7'h04;
  localparam logic [6:0] STATUS_ADDR = 7'h20;
  localparam logic [31:0] SLIP_ENABLES_RST = 32'h0000_0000;
  localparam logic [31:0] DET_SWAP_RST = 32'h0000_0000;
  localparam logic [31:0] PUMP_CFG_RST = 32'h0000_0000;

  // field positions
  localparam int SLIP_EN_BIT = 4;
  localparam int SLIP_OUT_EN_BIT = 13;
  localparam int SWAP_BIT = 4;
  localparam int SLIP_DELAY_LSB = 0;
  localparam int UP_CUR_LSB = 0;
  localparam int LOWER_CUR_LSB = 7;
  localparam int OFFSET_LSB = 14;
  localparam int OFFSET_UP_BIT = 21;
  localparam int OFFSET_LOWER_BIT = 22;
  localparam int HIGH_GAIN_BIT = 23;
  localparam int FORCE_UP_BIT = 26;
  localparam int FORCE_LOWER_BIT = 27;

  // serial frame: one read flag, seven address bits, 32 data bits
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] FRAME_BITS = 6'h28;

  // pump current scale in microamps
  localparam logic [13:0] PUMP_STEP_UA = 14'h0014;
  localparam logic [13:0] HIGH_GAIN_UA = 14'h0DAC;

  typedef enum logic [1:0] {
    GUARD_WATCH = 2'b00,
    GUARD_HOLD_UP = 2'b01,
    GUARD_HOLD_LOWER = 2'b10
  } guard_state_e;

  // total current one pump side delivers for a given setting
  function automatic logic [13:0] pump_drive_ua(input logic [6:0] code, input logic [6:0] offs,
                                                input logic add_offs, input logic high_gain);
    logic [13:0] sum;
    sum = 14'(code) * PUMP_STEP_UA;
    if (add_offs) begin
      sum = sum + 14'(offs) * PUMP_STEP_UA;
    end
    if (high_gain) begin
      sum = sum + HIGH_GAIN_UA;
    end
    return sum;
  endfunction : pump_drive_ua

endpackage : pfd_pkg

/* File: rtl/pump_ctrl_if.sv */
`timescale 1ns/100ps
interface pump_ctrl_if;
  import pfd_pkg::*;
  logic ref_edge;
  logic osc_edge;
  logic swap;
  logic det_up;
  logic det_lower;
  logic guard_en;
  logic [2:0] slip_delay;
  logic hold_up;
  logic hold_lower;
  guard_state_e guard_state;
  modport ctrl(output ref_edge, osc_edge, swap, guard_en, slip_delay,
               input det_up, det_lower, hold_up, hold_lower, guard_state);
  modport core(input ref_edge, osc_edge, swap, output det_up, det_lower);
  modport guard(input ref_edge, osc_edge, swap, det_up, det_lower, guard_en, slip_delay,
                output hold_up, hold_lower, guard_state);
endinterface : pump_ctrl_if

/* File: rtl/phase_comparator_core.sv */
`timescale 1ns/100ps
module phase_comparator_core
  import pfd_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // detector side of the control bundle
  pump_ctrl_if.core pc
);

  logic up_q, up_d, lower_q, lower_d;
  logic a_edge, b_edge;

  // swap exchanges which input drives the up side, reversing gain
  assign a_edge = pc.swap ? pc.osc_edge : pc.ref_edge;
  assign b_edge = pc.swap ? pc.ref_edge : pc.osc_edge;
  // edges set their side; both high resets the pair
  assign up_d = (up_q | a_edge) & ~(up_q & lower_q);
  assign lower_d = (lower_q | b_edge) & ~(up_q & lower_q);

  // detector flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      up_q <= 1'b0;
      lower_q <= 1'b0;
    end else begin
      up_q <= up_d;
      lower_q <= lower_d;
    end
  end

  assign pc.det_up = up_q;
  assign pc.det_lower = lower_q;

endmodule : phase_comparator_core

/* File: rtl/slip_guard.sv */
`timescale 1ns/100ps
module slip_guard
  import pfd_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // guard side of the control bundle
  pump_ctrl_if.guard pg
);

  guard_state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d, cnt_cur;
  logic dir_q, dir_d;
  logic a_edge, b_edge, up_slip, lower_slip, slip, trigger;

  // a slip is a second edge on a side that is already pending
  assign a_edge = pg.swap ? pg.osc_edge : pg.ref_edge;
  assign b_edge = pg.swap ? pg.ref_edge : pg.osc_edge;
  assign up_slip = a_edge & pg.det_up & ~pg.det_lower;
  assign lower_slip = b_edge & pg.det_lower & ~pg.det_up;
  assign slip = up_slip | lower_slip;
  // delay field sets how many same-way slips arm a hold
  assign cnt_cur = (up_slip == dir_q) ? cnt_q : 3'h0;
  assign trigger = slip & (cnt_cur == pg.slip_delay);
  assign cnt_d = trigger ? 3'h0 : (slip ? cnt_cur + 3'h1 : cnt_q);
  assign dir_d = slip ? up_slip : dir_q;

  // hold until the error flips sign, i.e. frequency near zero
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      GUARD_WATCH: begin
        if (trigger) begin
          state_d = up_slip ? GUARD_HOLD_UP : GUARD_HOLD_LOWER;
        end
      end
      GUARD_HOLD_UP: begin
        if (b_edge & pg.det_lower & ~pg.det_up) begin
          state_d = GUARD_WATCH;
        end
      end
      GUARD_HOLD_LOWER: begin
        if (up_slip) begin
          state_d = GUARD_WATCH;
        end
      end
      default: state_d = GUARD_WATCH;
    endcase
    if (!pg.guard_en) begin
      state_d = GUARD_WATCH;
    end
  end

  // state, run counter and direction
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= GUARD_WATCH;
      cnt_q <= 3'h0;
      dir_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= pg.guard_en ? cnt_d : 3'h0;
      dir_q <= dir_d;
    end
  end

  assign pg.hold_up = (state_q == GUARD_HOLD_UP);
  assign pg.hold_lower = (state_q == GUARD_HOLD_LOWER);
  assign pg.guard_state = state_q;

endmodule : slip_guard

/* File: rtl/pfd_pump_top.sv */
`timescale 1ns/100ps
module pfd_pump_top
  import pfd_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  // detector inputs
  input wire logic I_REF_EDGE,
  input wire logic I_OSC_EDGE,
  // serial configuration port
  input wire logic I_SPI_CLK,
  input wire logic I_SPI_SEL_N,
  input wire logic I_SPI_DATA,
  output logic O_SPI_DATA,
  // pump drive
  output logic O_PUMP_UP,
  output logic O_PUMP_LOWER,
  // pump current settings
  output logic [6:0] O_UP_CURRENT,
  output logic [6:0] O_LOWER_CURRENT,
  output logic [6:0] O_OFFSET_CURRENT,
  output logic O_OFFSET_TO_UP,
  output logic O_OFFSET_TO_LOWER,
  output logic O_HIGH_GAIN_PUMP,
  output logic [13:0] O_UP_DRIVE_UA,
  output logic [13:0] O_LOWER_DRIVE_UA,
  // saturation flags to the companion divider
  output logic O_UP_SATURATION_FLAG,
  output logic O_DOWN_SATURATION_FLAG
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int N_SYNC = 5;
  logic [N_SYNC-1:0] pin_raw;
  logic [N_SYNC-1:0] sync1_q, sync2_q, sync3_q, lvl_q, prev_q;

  assign pin_raw = {I_SPI_DATA, I_SPI_SEL_N, I_SPI_CLK, I_OSC_EDGE, I_REF_EDGE};

  // a level only moves once stages two and three agree
  generate
    for (genvar g = 0; g < N_SYNC; g++) begin : g_sync
      always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
          // every stage starts at the pin's idle level, so no false select edge follows reset
          sync1_q[g] <= (g == 3);
          sync2_q[g] <= (g == 3);
          sync3_q[g] <= (g == 3);
          lvl_q[g] <= (g == 3);
          prev_q[g] <= (g == 3);
        end else begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g]) begin
            lvl_q[g] <= sync3_q[g];
          end
          prev_q[g] <= lvl_q[g];
        end
      end
    end
  endgenerate

  logic ref_rise, osc_rise, sclk_rise, sel_act, frame_end, sdi_lvl;

  // edge pulses, one cycle each; select and data stay as levels
  assign ref_rise = lvl_q[0] & ~prev_q[0];
  assign osc_rise = lvl_q[1] & ~prev_q[1];
  assign sclk_rise = lvl_q[2] & ~prev_q[2];
  assign sel_act = ~lvl_q[3];
  assign frame_end = lvl_q[3] & ~prev_q[3];
  assign sdi_lvl = lvl_q[4];

  // ---------------------------------------------------------------
  // serial configuration port
  // ---------------------------------------------------------------
  logic [5:0] bit_cnt_q;
  logic [39:0] shift_in_q;
  logic [31:0] shift_out_q;
  logic spi_do_q;
  logic [6:0] rd_addr;
  logic [6:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic wr_commit;
  logic addr_done;

  // the address is complete on the eighth clock of the frame
  assign addr_done = sclk_rise & sel_act & (bit_cnt_q == CMD_BITS - 6'h01);
  assign rd_addr = {shift_in_q[5:0], sdi_lvl};
  assign wr_addr = shift_in_q[38:32];
  assign wr_data = shift_in_q[31:0];
  // short or long frames are dropped so half a word never lands
  assign wr_commit = frame_end & (bit_cnt_q == FRAME_BITS) & ~shift_in_q[39];

  // shift register and bit counter
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bit_cnt_q <= 6'h00;
      shift_in_q <= 40'h00_0000_0000;
    end else if (!sel_act) begin
      bit_cnt_q <= frame_end ? bit_cnt_q : 6'h00;
    end else if (sclk_rise) begin
      shift_in_q <= {shift_in_q[38:0], sdi_lvl};
      bit_cnt_q <= (bit_cnt_q == 6'h3F) ? bit_cnt_q : bit_cnt_q + 6'h01;
    end
  end

  // read data loads after the address, then shifts out msb first
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      shift_out_q <= 32'h0000_0000;
      spi_do_q <= 1'b0;
    end else begin
      if (addr_done) begin
        shift_out_q <= rd_word;
      end else if (sclk_rise & sel_act) begin
        shift_out_q <= {shift_out_q[30:0], 1'b0};
      end
      spi_do_q <= sel_act & shift_out_q[31];
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [31:0] slip_en_q;
  logic [31:0] swap_cfg_q;
  logic [31:0] pump_cfg_q;

  // writes to unmapped or read-only addresses are ignored
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      slip_en_q <= SLIP_ENABLES_RST;
      swap_cfg_q <= DET_SWAP_RST;
      pump_cfg_q <= PUMP_CFG_RST;
    end else if (wr_commit) begin
      if (wr_addr == SLIP_ENABLES_ADDR) begin
        slip_en_q <= wr_data;
      end
      if (wr_addr == DET_SWAP_ADDR) begin
        swap_cfg_q <= wr_data;
      end
      if (wr_addr == PUMP_CFG_ADDR) begin
        pump_cfg_q <= wr_data;
      end
    end
  end

  // read mux; unmapped addresses read zero
  assign rd_word = (rd_addr == SLIP_ENABLES_ADDR) ? slip_en_q :
                   (rd_addr == DET_SWAP_ADDR) ? swap_cfg_q :
                   (rd_addr == PUMP_CFG_ADDR) ? pump_cfg_q :
                   (rd_addr == STATUS_ADDR) ? status_word : 32'h0000_0000;

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  logic guard_out_en, force_up, force_lower, offs_up, offs_lower, high_gain;
  logic [6:0] up_code, lower_code, offs_code;

  assign guard_out_en = slip_en_q[SLIP_OUT_EN_BIT];
  assign force_up = pump_cfg_q[FORCE_UP_BIT];
  assign force_lower = pump_cfg_q[FORCE_LOWER_BIT];
  assign up_code = pump_cfg_q[UP_CUR_LSB +: 7];
  assign lower_code = pump_cfg_q[LOWER_CUR_LSB +: 7];
  assign offs_code = pump_cfg_q[OFFSET_LSB +: 7];
  assign offs_up = pump_cfg_q[OFFSET_UP_BIT];
  assign offs_lower = pump_cfg_q[OFFSET_LOWER_BIT];
  assign high_gain = pump_cfg_q[HIGH_GAIN_BIT];

  // ---------------------------------------------------------------
  // detector and slip guard
  // ---------------------------------------------------------------
  pump_ctrl_if pc_bus();

  assign pc_bus.ref_edge = ref_rise;
  assign pc_bus.osc_edge = osc_rise;
  assign pc_bus.swap = swap_cfg_q[SWAP_BIT];
  // the guard runs only with both enables set
  assign pc_bus.guard_en = slip_en_q[SLIP_EN_BIT] & guard_out_en;
  assign pc_bus.slip_delay = swap_cfg_q[SLIP_DELAY_LSB +: 3];

  phase_comparator_core u_core (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .pc(pc_bus.core)
  );

  slip_guard u_guard (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .pg(pc_bus.guard)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic pump_up_q, pump_lower_q, up_sat_q, dn_sat_q;
  logic [6:0] up_cur_q, lower_cur_q, offs_cur_q;
  logic offs_up_q, offs_lower_q, high_gain_q;
  logic [13:0] up_ua_q, lower_ua_q;
  logic ref_leads, osc_leads;
  logic pump_up_d, pump_lower_d;

  // saturation flags name the physical input, so undo the swap
  assign ref_leads = pc_bus.swap ? pc_bus.det_lower : pc_bus.det_up;
  assign osc_leads = pc_bus.swap ? pc_bus.det_up : pc_bus.det_lower;
  // forcing wins over the detector; both sides may be forced at once
  assign pump_up_d = force_up | pc_bus.hold_up | pc_bus.det_up;
  assign pump_lower_d = force_lower | pc_bus.hold_lower | pc_bus.det_lower;

  // every output leaves through a flop
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pump_up_q <= 1'b0;
      pump_lower_q <= 1'b0;
      up_sat_q <= 1'b0;
      dn_sat_q <= 1'b0;
      up_cur_q <= 7'h00;
      lower_cur_q <= 7'h00;
      offs_cur_q <= 7'h00;
      offs_up_q <= 1'b0;
      offs_lower_q <= 1'b0;
      high_gain_q <= 1'b0;
      up_ua_q <= 14'h0000;
      lower_ua_q <= 14'h0000;
    end else begin
      pump_up_q <= pump_up_d;
      pump_lower_q <= pump_lower_d;
      up_sat_q <= guard_out_en & ref_leads;
      dn_sat_q <= guard_out_en & osc_leads;
      up_cur_q <= up_code;
      lower_cur_q <= lower_code;
      offs_cur_q <= offs_code;
      offs_up_q <= offs_up;
      offs_lower_q <= offs_lower;
      high_gain_q <= high_gain;
      up_ua_q <= pump_drive_ua(up_code, offs_code, offs_up, high_gain);
      lower_ua_q <= pump_drive_ua(lower_code, offs_code, offs_lower, high_gain);
    end
  end

  // live state for software
  assign status_word = {24'h00_0000, 2'b00, pc_bus.guard_state, pc_bus.det_up, pc_bus.det_lower,
                        up_sat_q, dn_sat_q};

  assign O_SPI_DATA = spi_do_q;
  assign O_PUMP_UP = pump_up_q;
  assign O_PUMP_LOWER = pump_lower_q;
  assign O_UP_CURRENT = up_cur_q;
  assign O_LOWER_CURRENT = lower_cur_q;
  assign O_OFFSET_CURRENT = offs_cur_q;
  assign O_OFFSET_TO_UP = offs_up_q;
  assign O_OFFSET_TO_LOWER = offs_lower_q;
  assign O_HIGH_GAIN_PUMP = high_gain_q;
  assign O_UP_DRIVE_UA = up_ua_q;
  assign O_LOWER_DRIVE_UA = lower_ua_q;
  assign O_UP_SATURATION_FLAG = up_sat_q;
  assign O_DOWN_SATURATION_FLAG = dn_sat_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_swap_reverses_gain: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    pc_bus.swap && osc_rise && !ref_rise && !pc_bus.det_up && !pc_bus.det_lower |=> pc_bus.det_up && !pc_bus.det_lower)
    else $error("swapped oscillator edge did not raise up side");

  a_detector_pair_reset: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    pc_bus.det_up && pc_bus.det_lower |=> !pc_bus.det_up && !pc_bus.det_lower)
    else $error("detector pair did not clear");

  a_force_up_holds: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    pump_cfg_q[FORCE_UP_BIT] [*2] |-> O_PUMP_UP)
    else $error("forced up pump not active");

  a_force_lower_holds: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    pump_cfg_q[FORCE_LOWER_BIT] |=> O_PUMP_LOWER || !$past(force_lower))
    else $error("forced lower pump not active");

  a_guard_hold_drives: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    pc_bus.hold_lower |=> O_PUMP_LOWER)
    else $error("slip hold did not drive lower pump");

  a_guard_needs_enables: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    !pc_bus.guard_en |=> !pc_bus.hold_up && !pc_bus.hold_lower)
    else $error("slip hold without both enables");

  a_up_code_routed: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ##1 O_UP_CURRENT == $past(pump_cfg_q[6:0]) && O_LOWER_CURRENT == $past(pump_cfg_q[13:7]))
    else $error("pump current code misrouted");

  a_offset_to_up: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    pump_cfg_q[OFFSET_UP_BIT] && !pump_cfg_q[HIGH_GAIN_BIT] |=>
      O_UP_DRIVE_UA == 14'($past(up_code)) * PUMP_STEP_UA + 14'($past(offs_code)) * PUMP_STEP_UA)
    else $error("offset not added to up pump");

  a_high_gain_alone: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    high_gain && up_code == 7'h00 && !offs_up |=> O_UP_DRIVE_UA == HIGH_GAIN_UA && O_HIGH_GAIN_PUMP)
    else $error("high gain current wrong with zero code");

  a_sat_follows_lead: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    guard_out_en && ref_leads |=> O_UP_SATURATION_FLAG ##1
      (O_DOWN_SATURATION_FLAG || !$past(osc_leads) || !$past(guard_out_en)))
    else $error("saturation flag does not follow lead");

endmodule : pfd_pump_top

/* File: bench/edge_source.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// divided edge source standing in for the companion divider
// ---------------------------------------------------------------
module edge_source (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // request and its lag in clocks
  input wire logic i_go,
  input wire logic [7:0] i_lag,
  // divided edge
  output logic o_edge
);
  int cnt_q;
  // pulse is 8 clocks wide so the three-stage sync always catches it
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 0;
    end else if (i_go) begin
      cnt_q <= int'(i_lag) + 8;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  // low during the lag and between pulses
  assign o_edge = (cnt_q > 0) && (cnt_q <= 8);
endmodule : edge_source

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module testbench;
  import pfd_pkg::*;
  logic clk, rst, sck, sel_n, sdi, ref_go, osc_go;
  logic [7:0] ref_lag, osc_lag;
  wire logic ref_edge, osc_edge, sdo, pump_up, pump_lower, up_sat, dn_sat, off_up, off_low, hg;
  wire logic [6:0] up_cur, low_cur, off_cur;
  wire logic [13:0] up_ua, low_ua;
  int n_errors = 0;
  int n_tests = 0;
  logic [31:0] rd, cfg;
  logic [6:0] ra[3] = '{SLIP_ENABLES_ADDR, DET_SWAP_ADDR, PUMP_CFG_ADDR};
  logic [31:0] rv[3] = '{SLIP_ENABLES_RST, DET_SWAP_RST, PUMP_CFG_RST};
  // offset enabled in both rows, as a fractional setup should be
  logic [6:0] pc_up[2] = '{7'h7F, 7'h00};
  logic [6:0] pc_low[2] = '{7'h01, 7'h00};
  logic [6:0] pc_off[2] = '{7'h20, 7'h05};
  logic pc_oup[2] = '{1'b1, 1'b0};
  logic pc_odn[2] = '{1'b0, 1'b1};
  logic pc_hg[2] = '{1'b0, 1'b1};

  pfd_pump_top uut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_REF_EDGE(ref_edge), .I_OSC_EDGE(osc_edge),
    .I_SPI_CLK(sck), .I_SPI_SEL_N(sel_n), .I_SPI_DATA(sdi), .O_SPI_DATA(sdo),
    .O_PUMP_UP(pump_up), .O_PUMP_LOWER(pump_lower), .O_UP_CURRENT(up_cur), .O_LOWER_CURRENT(low_cur),
    .O_OFFSET_CURRENT(off_cur), .O_OFFSET_TO_UP(off_up), .O_OFFSET_TO_LOWER(off_low),
    .O_HIGH_GAIN_PUMP(hg), .O_UP_DRIVE_UA(up_ua), .O_LOWER_DRIVE_UA(low_ua),
    .O_UP_SATURATION_FLAG(up_sat), .O_DOWN_SATURATION_FLAG(dn_sat));
  edge_source ref_gen (.i_clk(clk), .i_rst(rst), .i_go(ref_go), .i_lag(ref_lag), .o_edge(ref_edge));
  edge_source osc_gen (.i_clk(clk), .i_rst(rst), .i_go(osc_go), .i_lag(osc_lag), .o_edge(osc_edge));

  // 100 MHz system clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic close_out;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // one 40-bit frame; pins held 6 clocks each since the port samples them
  task automatic spi(input logic rdf, input logic [6:0] a, input logic [31:0] wd, output logic [31:0] q);
    logic [39:0] fr;
    fr = {rdf, a, wd};
    q = 32'h0;
    sel_n = 0;
    cyc(6);
    for (int j = 0; j < 40; j++) begin
      sdi = fr[39-j];
      sck = 0;
      cyc(6);
      if (j >= 8) q = {q[30:0], sdo};
      sck = 1;
      cyc(6);
    end
    sck = 0;
    cyc(6);
    sel_n = 1;
    cyc(12);
  endtask : spi

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    spi(1'b0, a, d, dummy);
  endtask : wr

  task automatic fire(input bit is_ref, input int lag);
    if (is_ref) begin
      ref_lag = 8'(lag);
      ref_go = 1;
    end else begin
      osc_lag = 8'(lag);
      osc_go = 1;
    end
    cyc(1);
    ref_go = 0;
    osc_go = 0;
  endtask : fire

  // bounded wait for one pump output to reach a level
  task automatic wait_pump(input bit up_side, input logic v);
    int k;
    k = 0;
    while (((up_side ? pump_up : pump_lower) !== v) && k < 40) begin
      cyc(1);
      k++;
    end
    if ((up_side ? pump_up : pump_lower) !== v) begin
      n_errors++;
      $display("BAD pump wait exp %0h got %0h", v, up_side ? pump_up : pump_lower);
      close_out();
    end
  endtask : wait_pump

  // leading edge sets one side, lagging edge clears the pair
  task automatic pfd_pair(input bit ref_first, input bit swap, input bit sat_en);
    bit up_side;
    up_side = ref_first ^ swap;
    fire(ref_first, 0);
    wait_pump(up_side, 1'b1);
    `CHK("other pump", 1'b0, up_side ? pump_lower : pump_up)
    `CHK("up sat", 1'(sat_en & ref_first), up_sat)
    `CHK("down sat", 1'(sat_en & ~ref_first), dn_sat)
    fire(!ref_first, 3);
    wait_pump(up_side, 1'b0);
    cyc(2);
    `CHK("pumps idle", 2'b00, {pump_up, pump_lower})
  endtask : pfd_pair

  function automatic logic [13:0] exp_ua(input logic [6:0] c, input logic [6:0] o, input logic a, input logic h);
    return 14'(c) * 14'h0014 + (a ? 14'(o) * 14'h0014 : 14'h0000) + (h ? 14'h0DAC : 14'h0000);
  endfunction : exp_ua

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1; sck = 0; sel_n = 1; sdi = 0; ref_go = 0; osc_go = 0; ref_lag = 8'h00; osc_lag = 8'h00;
    cyc(8);
    rst = 0;
    cyc(2);
    // reset values, write and read back, unmapped address
    for (int i = 0; i < 3; i++) begin
      spi(1'b1, ra[i], 32'h0, rd);
      `CHK("reset value", rv[i], rd)
      wr(ra[i], 32'hA5C3_0F5A);
      spi(1'b1, ra[i], 32'h0, rd);
      `CHK("readback", 32'hA5C3_0F5A, rd)
      wr(ra[i], 32'h0000_0000);
    end
    wr(7'h05, 32'h1234_5678);
    spi(1'b1, 7'h05, 32'h0, rd);
    `CHK("unmapped read", 32'h0, rd)
    // pump current fields and drive currents
    for (int i = 0; i < 2; i++) begin
      cfg = {8'h00, pc_hg[i], pc_odn[i], pc_oup[i], pc_off[i], pc_low[i], pc_up[i]};
      wr(PUMP_CFG_ADDR, cfg);
      `CHK("up code", pc_up[i], up_cur)
      `CHK("down code", pc_low[i], low_cur)
      `CHK("offset code", pc_off[i], off_cur)
      `CHK("offset sides", {pc_oup[i], pc_odn[i]}, {off_up, off_low})
      `CHK("high gain", pc_hg[i], hg)
      `CHK("up drive", exp_ua(pc_up[i], pc_off[i], pc_oup[i], pc_hg[i]), up_ua)
      `CHK("down drive", exp_ua(pc_low[i], pc_off[i], pc_odn[i], pc_hg[i]), low_ua)
    end
    // forced outputs hold against the detector
    for (int f = 0; f < 2; f++) begin
      wr(PUMP_CFG_ADDR, (f == 1) ? 32'h0800_0000 : 32'h0400_0000);
      fire(f == 1, 0);
      cyc(12);
      `CHK("forced pump", 1'b1, (f == 1) ? pump_lower : pump_up)
      fire(f == 0, 0);
      cyc(12);
      `CHK("forced pump held", 1'b1, (f == 1) ? pump_lower : pump_up)
    end
    wr(PUMP_CFG_ADDR, 32'h0000_0000);
    cyc(4);
    `CHK("pumps released", 2'b00, {pump_up, pump_lower})
    // detector, swap and saturation flags
    pfd_pair(1'b1, 1'b0, 1'b0);
    pfd_pair(1'b0, 1'b0, 1'b0);
    wr(DET_SWAP_ADDR, 32'h0000_0010);
    pfd_pair(1'b1, 1'b1, 1'b0);
    pfd_pair(1'b0, 1'b1, 1'b0);
    wr(SLIP_ENABLES_ADDR, 32'h0000_2000);
    pfd_pair(1'b1, 1'b1, 1'b1);
    pfd_pair(1'b0, 1'b1, 1'b1);
    wr(DET_SWAP_ADDR, 32'h0000_0000);
    pfd_pair(1'b1, 1'b0, 1'b1);
    pfd_pair(1'b0, 1'b0, 1'b1);
    // slip guard: delay 0, delay 1, then output enable missing
    for (int t = 0; t < 3; t++) begin
      wr(DET_SWAP_ADDR, (t == 1) ? 32'h0000_0001 : 32'h0000_0000);
      wr(SLIP_ENABLES_ADDR, (t == 2) ? 32'h0000_0010 : 32'h0000_2010);
      for (int r = 0; r <= (t == 1) + 1; r++) begin
        if (r == (t == 1) + 1) begin
          spi(1'b1, STATUS_ADDR, 32'h0, rd);
          `CHK("guard before last slip", 2'b00, rd[5:4])
        end
        fire(1'b1, 0);
        cyc(20);
      end
      spi(1'b1, STATUS_ADDR, 32'h0, rd);
      `CHK("guard state", (t == 2) ? 2'b00 : 2'b01, rd[5:4])
      fire(1'b0, 0);
      cyc(20);
      `CHK("held up pump", 1'(t != 2), pump_up)
      // lower side pending alone, then slipping twice: leaves the up hold, then holds lower
      repeat (2) begin
        fire(1'b0, 0);
        cyc(20);
      end
      `CHK("hold up left", 1'b0, pump_up)
      spi(1'b1, STATUS_ADDR, 32'h0, rd);
      `CHK("guard after reversal", 2'b00, rd[5:4])
      fire(1'b0, 0);
      cyc(20);
      spi(1'b1, STATUS_ADDR, 32'h0, rd);
      `CHK("guard hold lower", (t == 2) ? 2'b00 : 2'b10, rd[5:4])
      fire(1'b1, 0);
      cyc(20);
      `CHK("held lower pump", 1'(t != 2), pump_lower)
      wr(SLIP_ENABLES_ADDR, 32'h0000_0000);
      cyc(4);
      `CHK("guard released", 2'b00, {pump_up, pump_lower})
      spi(1'b1, STATUS_ADDR, 32'h0, rd);
      `CHK("guard watch", 2'b00, rd[5:4])
    end
    close_out();
  end

  // cuts a hang short
  initial begin
    #800000;
    n_errors++;
    $display("BAD watchdog exp done got hang");
    close_out();
  end
endmodule : testbench
